// ==== src/tcs_pkg.sv ====
/*
 * Shared constants for the timer channel-1 capture/compare setup block:
 * register offsets, field positions, reset values and the filter table.
 * Assumes an APB master with 32-bit data and byte addresses.
 */
//
// Contract
// - Direction 00 output, 01 input from pin
// - Direction writable only while channel disabled
// - Capture every 1, 2, 4, 8 edges
// - Filter code zero samples input directly
// - Nonzero filter codes select divider and length
// - Enable bit permits captures in input mode
// - Output mode: disabled drives zero, no pad
// - Primary polarity one inverts output reference
// - Polarity pair selects rising, falling, both edges
// - Auxiliary polarity reads zero in output mode
// - Counter 16-bit RW at 0x24, resets zero
// - Capture loads counter, overwriting previous value
package tcs_pkg;

    localparam int          TCS_ADDR_W       = 8;
    localparam int          TCS_DATA_W       = 32;
    localparam int          TCS_REG_W        = 16;

    localparam logic [7:0]  TCS_OFF_MODE     = 8'h18;
    localparam logic [7:0]  TCS_OFF_ENPOL    = 8'h20;
    localparam logic [7:0]  TCS_OFF_COUNT    = 8'h24;
    localparam logic [7:0]  TCS_OFF_CAPT     = 8'h34;

    localparam logic [15:0] TCS_RST_MODE     = 16'h0000;
    localparam logic [15:0] TCS_RST_ENPOL    = 16'h0000;
    localparam logic [15:0] TCS_RST_COUNT    = 16'h0000;
    localparam logic [15:0] TCS_RST_CAPT     = 16'h0000;

    // Mode register fields
    localparam int          TCS_DIR_LSB      = 0;
    localparam int          TCS_PSC_LSB      = 2;
    localparam int          TCS_FLT_LSB      = 4;
    localparam int          TCS_MODE_USED_W  = 8;
    localparam logic [1:0]  TCS_DIR_OUTPUT   = 2'h0;
    localparam logic [1:0]  TCS_DIR_INPUT    = 2'h1;
    localparam logic [3:0]  TCS_FLT_BYPASS   = 4'h0;

    // Enable/polarity register fields
    localparam int          TCS_EN_BIT       = 0;
    localparam int          TCS_POL_BIT      = 1;
    localparam int          TCS_NPOL_BIT     = 3;

    // Edge selection as {auxiliary, primary}
    localparam logic [1:0]  TCS_EDGE_RISE    = 2'h0;
    localparam logic [1:0]  TCS_EDGE_FALL    = 2'h1;
    localparam logic [1:0]  TCS_EDGE_BOTH    = 2'h3;

    localparam int          TCS_DIV_W        = 5;
    localparam int          TCS_LEN_W        = 4;
    localparam logic [3:0]  TCS_LEN_BYPASS   = 4'h1;

    // Sampling divider as log2, indexed by filter code
    localparam logic [2:0]  TCS_FLT_DIV_LOG2 [16] = '{
        3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2,
        3'h3, 3'h3, 3'h4, 3'h4, 3'h4, 3'h5, 3'h5, 3'h5};

    // Filter length per code, figures kept as given
    localparam logic [3:0]  TCS_FLT_LEN [16] = '{
        4'h1, 4'h2, 4'h4, 4'h8, 4'h6, 4'h8, 4'h6, 4'h8,
        4'h8, 4'h8, 4'h5, 4'h5, 4'h8, 4'h5, 4'h6, 4'h8};

endpackage

// ==== src/tcs_filter.sv ====
/*
 * Digital input filter: passes a new level once a run of equal samples
 * reaches the programmed length. Assumes one-cycle sample enables.
 */
`timescale 1ns/1ps
module tcs_filter
    import tcs_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    input  wire logic                 sample_en,
    input  wire logic                 din,
    input  wire logic [TCS_LEN_W-1:0] len,
    output logic                      dout
);

    logic [TCS_LEN_W-1:0] run_q;
    logic [TCS_LEN_W-1:0] run_d;
    logic                 out_q;
    logic                 out_d;

    always_comb begin
        run_d = run_q;
        out_d = out_q;
        if (sample_en) begin
            if (din == out_q) begin
                run_d = '0;
            end else if (run_q + 4'h1 >= len) begin
                // Run complete: take the new level
                out_d = din;
                run_d = '0;
            end else begin
                run_d = run_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            run_q <= '0;
            out_q <= 1'b0;
        end else begin
            run_q <= run_d;
            out_q <= out_d;
        end
    end

    assign dout = out_q;

endmodule

// ==== src/tcs_channel.sv ====
/*
 * Timer channel 1 setup: APB register slave, counter, input filter,
 * edge select, capture divider, capture register and output gating.
 * Assumes APB3 master; pin input synchronous to clk_sys; counter steps
 * come as one-cycle pulses from the timer prescaler outside.
 */
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module tcs_channel
    import tcs_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [TCS_ADDR_W-1:0] paddr,
    input  wire logic [TCS_DATA_W-1:0] pwdata,
    output logic      [TCS_DATA_W-1:0] prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  count_step,
    input  wire logic                  timer_input_one,
    input  wire logic                  compare_reference_signal,
    output logic                       compare_output_one,
    output logic                       compare_output_enable,
    output logic      [TCS_REG_W-1:0]  counter_value,
    output logic      [TCS_REG_W-1:0]  capture_value,
    output logic                       capture_event
);

    ////////////////////////////////////////////////////////////////////
    // Registers and bus decode

    logic [TCS_MODE_USED_W-1:0] mode_q, mode_d;
    logic                       en_q, en_d;
    logic                       pol_q, pol_d;
    logic                       npol_q, npol_d;
    logic [TCS_REG_W-1:0]       count_q, count_d;
    logic [TCS_REG_W-1:0]       capt_q, capt_d;
    logic [TCS_DATA_W-1:0]      prdata_q, prdata_d;
    logic                       pready_q, pready_d;
    logic                       pslverr_q, pslverr_d;

    logic                       acc_first;
    logic                       wr_commit;
    logic                       hit_mode, hit_enpol, hit_count, hit_capt;
    logic                       mapped;
    logic                       is_input, is_output;
    logic                       capture_fire;
    logic [TCS_REG_W-1:0]       enpol_view;

    // Answer on the second access cycle so read data leave a flop
    assign acc_first = psel && penable && !pready_q;
    assign wr_commit = psel && penable && pready_q && pwrite && !pslverr_q;

    assign hit_mode  = (paddr == TCS_OFF_MODE);
    assign hit_enpol = (paddr == TCS_OFF_ENPOL);
    assign hit_count = (paddr == TCS_OFF_COUNT);
    assign hit_capt  = (paddr == TCS_OFF_CAPT);
    assign mapped    = hit_mode || hit_enpol || hit_count || hit_capt;

    assign is_output = (mode_q[TCS_DIR_LSB +: 2] == TCS_DIR_OUTPUT);
    assign is_input  = (mode_q[TCS_DIR_LSB +: 2] == TCS_DIR_INPUT);

    always_comb begin
        enpol_view               = '0;
        enpol_view[TCS_EN_BIT]   = en_q;
        enpol_view[TCS_POL_BIT]  = pol_q;
        enpol_view[TCS_NPOL_BIT] = npol_q;
    end

    always_comb begin
        pready_d  = acc_first;
        pslverr_d = acc_first && !mapped;
        prdata_d  = prdata_q;
        if (acc_first) begin
            prdata_d = '0;
            if (hit_mode) begin
                prdata_d[TCS_MODE_USED_W-1:0] = mode_q;
            end
            if (hit_enpol) begin
                prdata_d[TCS_REG_W-1:0] = enpol_view;
            end
            if (hit_count) begin
                prdata_d[TCS_REG_W-1:0] = count_q;
            end
            if (hit_capt) begin
                prdata_d[TCS_REG_W-1:0] = capt_q;
            end
        end
    end

    always_comb begin
        mode_d  = mode_q;
        en_d    = en_q;
        pol_d   = pol_q;
        npol_d  = npol_q;
        count_d = count_q;
        capt_d  = capt_q;
        if (count_step) begin
            count_d = count_q + 16'h0001;
        end
        if (capture_fire) begin
            capt_d = count_q;
        end
        if (wr_commit && hit_mode) begin
            mode_d[TCS_MODE_USED_W-1:TCS_PSC_LSB] =
                pwdata[TCS_MODE_USED_W-1:TCS_PSC_LSB];
            // Direction is locked while the channel runs
            if (!en_q) begin
                mode_d[TCS_DIR_LSB +: 2] = pwdata[TCS_DIR_LSB +: 2];
            end
        end
        if (wr_commit && hit_enpol) begin
            en_d   = pwdata[TCS_EN_BIT];
            pol_d  = pwdata[TCS_POL_BIT];
            npol_d = pwdata[TCS_NPOL_BIT];
        end
        // Software write to the counter wins over a step
        if (wr_commit && hit_count) begin
            count_d = pwdata[TCS_REG_W-1:0];
        end
        // Hardware capture wins over a software write
        if (wr_commit && hit_capt && !capture_fire) begin
            capt_d = pwdata[TCS_REG_W-1:0];
        end
        // Forced clear whenever the channel is an output
        if (mode_d[TCS_DIR_LSB +: 2] == TCS_DIR_OUTPUT) begin
            npol_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mode_q    <= TCS_RST_MODE[TCS_MODE_USED_W-1:0];
            en_q      <= TCS_RST_ENPOL[TCS_EN_BIT];
            pol_q     <= TCS_RST_ENPOL[TCS_POL_BIT];
            npol_q    <= TCS_RST_ENPOL[TCS_NPOL_BIT];
            count_q   <= TCS_RST_COUNT;
            capt_q    <= TCS_RST_CAPT;
            prdata_q  <= '0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            mode_q    <= mode_d;
            en_q      <= en_d;
            pol_q     <= pol_d;
            npol_q    <= npol_d;
            count_q   <= count_d;
            capt_q    <= capt_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sampling divider and input filter

    logic [3:0]           flt_code;
    logic [2:0]           div_log2;
    logic [TCS_DIV_W-1:0] div_mask;
    logic [TCS_DIV_W-1:0] div_q, div_d;
    logic                 sample_en;
    logic [TCS_LEN_W-1:0] flt_len;
    logic                 filtered;

    assign flt_code = mode_q[TCS_FLT_LSB +: 4];
    assign div_log2 = TCS_FLT_DIV_LOG2[flt_code];
    assign div_mask = TCS_DIV_W'((6'h01 << div_log2) - 6'h01);

    // Bypass samples every cycle, the dead-time sample rate
    assign sample_en = (flt_code == TCS_FLT_BYPASS) ||
                       ((div_q & div_mask) == div_mask);
    assign flt_len   = (flt_code == TCS_FLT_BYPASS) ? TCS_LEN_BYPASS
                                                    : TCS_FLT_LEN[flt_code];

    always_comb begin
        div_d = div_q + 5'h01;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end

    tcs_filter u_filter (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .sample_en (sample_en),
        .din       (timer_input_one),
        .len       (flt_len),
        .dout      (filtered)
    );

    ////////////////////////////////////////////////////////////////////
    // Edge select, capture divider, capture pulse

    logic       filt_prev_q, filt_prev_d;
    logic       rise, fall;
    logic       edge_hit;
    logic [2:0] edge_cnt_q, edge_cnt_d;
    logic [2:0] edge_last;
    logic       cap_evt_q, cap_evt_d;

    assign rise = filtered && !filt_prev_q;
    assign fall = !filtered && filt_prev_q;

    // Reserved pair 10 selects no edge at all
    always_comb begin
        unique case ({npol_q, pol_q})
            TCS_EDGE_RISE: edge_hit = rise;
            TCS_EDGE_FALL: edge_hit = fall;
            TCS_EDGE_BOTH: edge_hit = rise || fall;
            default:       edge_hit = 1'b0;
        endcase
    end

    // Divide by 1, 2, 4 or 8 qualifying edges
    assign edge_last    = 3'((4'h1 << mode_q[TCS_PSC_LSB +: 2]) - 4'h1);
    assign capture_fire = is_input && en_q && edge_hit &&
                          (edge_cnt_q == edge_last);

    always_comb begin
        filt_prev_d = filtered;
        cap_evt_d   = capture_fire;
        edge_cnt_d  = edge_cnt_q;
        if (!en_q || !is_input) begin
            edge_cnt_d = '0;
        end else if (edge_hit) begin
            edge_cnt_d = capture_fire ? 3'h0 : edge_cnt_q + 3'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            filt_prev_q <= 1'b0;
            edge_cnt_q  <= '0;
            cap_evt_q   <= 1'b0;
        end else begin
            filt_prev_q <= filt_prev_d;
            edge_cnt_q  <= edge_cnt_d;
            cap_evt_q   <= cap_evt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output gating

    logic oc_q, oc_d;
    logic oc_en_q, oc_en_d;

    // Input or reserved direction keeps the pad released
    always_comb begin
        oc_d    = 1'b0;
        oc_en_d = 1'b0;
        if (is_output && en_q) begin
            oc_d    = compare_reference_signal ^ pol_q;
            oc_en_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            oc_q    <= 1'b0;
            oc_en_q <= 1'b0;
        end else begin
            oc_q    <= oc_d;
            oc_en_q <= oc_en_d;
        end
    end

    assign compare_output_one    = oc_q;
    assign compare_output_enable = oc_en_q;
    assign counter_value         = count_q;
    assign capture_value         = capt_q;
    assign capture_event         = cap_evt_q;
    assign prdata                = prdata_q;
    assign pready                = pready_q;
    assign pslverr               = pslverr_q;

endmodule

// ==== verif/tcs_pin_model.sv ====
/*
 * Far-side model: drives the timer input pin and the compare reference.
 * Assumes its tasks are called just after a rising clock edge.
 */
`timescale 1ns/1ps
module tcs_pin_model (
    input  wire logic clk_sys,
    output logic      timer_input_one,
    output logic      compare_reference_signal
);
    initial begin
        timer_input_one          = 1'b0;
        compare_reference_signal = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Hold sets the pace: short is a prompt source, long a slow one
    task automatic toggle(input int n, input int hold);
        repeat (n) begin
            timer_input_one <= ~timer_input_one;
            repeat (hold) @(posedge clk_sys);
        end
    endtask

    task automatic set_ref(input logic b);
        compare_reference_signal <= b;
    endtask
endmodule

// ==== verif/tcs_channel_chk.sv ====
/*
 * Port-level checks for the channel setup block.
 * Assumes it is bound into every instance of tcs_channel.
 */
`timescale 1ns/1ps
module tcs_channel_chk
    import tcs_pkg::*;
(
    input wire logic                  clk_sys,
    input wire logic                  reset,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [TCS_ADDR_W-1:0] paddr,
    input wire logic [TCS_DATA_W-1:0] pwdata,
    input wire logic [TCS_DATA_W-1:0] prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic                  count_step,
    input wire logic                  timer_input_one,
    input wire logic                  compare_reference_signal,
    input wire logic                  compare_output_one,
    input wire logic                  compare_output_enable,
    input wire logic [TCS_REG_W-1:0]  counter_value,
    input wire logic [TCS_REG_W-1:0]  capture_value,
    input wire logic                  capture_event
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    logic wr_act;
    logic cnt_wr;
    logic cap_wr;
    assign wr_act = psel && pwrite;
    assign cnt_wr = wr_act && penable && pready && paddr == TCS_OFF_COUNT;
    assign cap_wr = wr_act && penable && pready && paddr == TCS_OFF_CAPT;

    ////////////////////////////////////////////////////////////////////////
    wait_state_a: assert property (psel && penable && !$past(penable) |->
        !pready ##1 pready) else $error("No single wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    err_read_a: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
        else $error("Bad error response");
    upper_zero_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
        else $error("Upper read bits set");
    out_gate_a: assert property (compare_output_one |-> compare_output_enable)
        else $error("Output high with pad off");
    out_follow_a: assert property (compare_output_enable && $past(compare_output_enable)
        && !$past(wr_act) && !$past(wr_act, 2) |->
        (compare_output_one ^ $past(compare_output_one)) ==
        ($past(compare_reference_signal) ^ $past(compare_reference_signal, 2)))
        else $error("Output ignores reference");
    step_inc_a: assert property (count_step && !cnt_wr |=>
        counter_value == $past(counter_value) + 16'h1) else $error("Counter missed a step");
    count_hold_a: assert property (counter_value != $past(counter_value) |->
        $past(count_step) || $past(cnt_wr)) else $error("Counter moved by itself");
    // Capture register and event pulse leave the same edge
    capt_event_a: assert property (capture_value != $past(capture_value) &&
        !$past(cap_wr) |-> capture_event) else $error("Capture without event");
    capt_value_a: assert property (capture_event |->
        capture_value == $past(counter_value)) else $error("Wrong captured value");

    cover property (capture_event);
    cover property (compare_output_enable && compare_output_one);
    cover property (pslverr);
endmodule

bind tcs_channel tcs_channel_chk tcs_channel_chk_i (
    .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_step(count_step), .timer_input_one(timer_input_one),
    .compare_reference_signal(compare_reference_signal),
    .compare_output_one(compare_output_one), .compare_output_enable(compare_output_enable),
    .counter_value(counter_value), .capture_value(capture_value),
    .capture_event(capture_event)
);

// ==== verif/testbench.sv ====
/*
 * Self-checking bench for the channel setup block: APB tasks, pin model,
 * random captures. Assumes the checker binds itself to the design.
 */
`timescale 1ns/1ps
module testbench
    import tcs_pkg::*;
;
    logic        clk_sys     = 1'b0;
    logic        reset       = 1'b1;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [7:0]  paddr       = 8'h00;
    logic [31:0] pwdata      = 32'h0;
    logic        count_step  = 1'b0;
    logic        step_rnd    = 1'b0;
    logic        step_man    = 1'b0;
    logic        pready, pslverr, tin, cref, cout, coen, cevt, er, st;
    logic [31:0] prdata, rd, v, rs;
    logic [15:0] cnt, capv;
    logic [3:0]  f;
    logic [1:0]  e, p;
    integer      seed        = 32'h176ec13a;
    int          error_cnt   = 0;
    int          comparisons = 0;
    int          cap_cnt     = 0;
    int          base, n, t, h;
    logic [1:0]  edges [3]   = '{TCS_EDGE_RISE, TCS_EDGE_FALL, TCS_EDGE_BOTH};
    logic [7:0]  offs [4]    = '{TCS_OFF_MODE, TCS_OFF_ENPOL, TCS_OFF_COUNT, TCS_OFF_CAPT};

    tcs_channel tcs_channel_i (
        .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .count_step(count_step), .timer_input_one(tin), .compare_reference_signal(cref),
        .compare_output_one(cout), .compare_output_enable(coen), .counter_value(cnt),
        .capture_value(capv), .capture_event(cevt)
    );
    tcs_pin_model tcs_pin_model_i (
        .clk_sys(clk_sys), .timer_input_one(tin), .compare_reference_signal(cref)
    );

    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        rs = $random(seed);
        count_step <= step_rnd ? rs[0] : step_man;
        if (cevt === 1'b1) cap_cnt <= cap_cnt + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic err);
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, er);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
        apb(1'b0, a, 32'h0, rd, er);
        chk(rd, exp);
        chk({31'h0, er}, {31'h0, eexp});
    endtask

    // Edges seen from a known start level, then divided down
    function automatic int exp_caps(logic s, int tg, logic [1:0] ed, logic [1:0] ps);
        int rises;
        int q;
        rises = s ? tg / 2 : (tg + 1) / 2;
        q = (ed == TCS_EDGE_BOTH) ? tg : (ed == TCS_EDGE_FALL) ? tg - rises : rises;
        return q >> ps;
    endfunction

    task automatic end_sim;
        $display("Mismatches %0d, comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        foreach (offs[i]) rdchk(offs[i], 32'h0, 1'b0);
        rdchk(8'h1c, 32'h0, 1'b1);
        v = $random(seed);
        wr(TCS_OFF_COUNT, {16'h0, v[15:0]});
        n = 1 + {$random(seed)} % 20;
        step_man <= 1'b1;
        repeat (n) @(posedge clk_sys);
        step_man <= 1'b0;
        rdchk(TCS_OFF_COUNT, {16'h0, v[15:0] + 16'(n)}, 1'b0);
        chk({16'h0, cnt}, {16'h0, v[15:0] + 16'(n)});
        // Output mode and disabled: no capture can disturb the write
        wr(TCS_OFF_CAPT, {16'h0, v[31:16]});
        rdchk(TCS_OFF_CAPT, {16'h0, v[31:16]}, 1'b0);
        chk({16'h0, capv}, {16'h0, v[31:16]});
        wr(TCS_OFF_ENPOL, 32'h1);
        wr(TCS_OFF_MODE, 32'hf5);
        rdchk(TCS_OFF_MODE, 32'hf4, 1'b0);
        for (int i = 0; i < 2; i++) begin
            wr(TCS_OFF_ENPOL, 32'h9 | {30'h0, i[0], 1'b0});
            rdchk(TCS_OFF_ENPOL, 32'h1 | {30'h0, i[0], 1'b0}, 1'b0);
            repeat (4) begin
                v = $random(seed);
                tcs_pin_model_i.set_ref(v[0]);
                repeat (3) @(posedge clk_sys);
                chk({30'h0, coen, cout}, {30'h0, 1'b1, v[0] ^ i[0]});
            end
        end
        wr(TCS_OFF_ENPOL, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk({30'h0, coen, cout}, 32'h0);
        step_rnd <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            e = edges[i % 3];
            p = 2'(i / 3);
            v = $random(seed);
            f = {2'b00, v[1:0]};
            // Polarity settles while disabled so enabling adds no edge
            wr(TCS_OFF_ENPOL, {28'h0, e[1], 1'b0, e[0], 1'b0});
            wr(TCS_OFF_MODE, {24'h0, f, p, TCS_DIR_INPUT});
            wr(TCS_OFF_ENPOL, {28'h0, e[1], 1'b0, e[0], 1'b1});
            base = cap_cnt;
            st = tin;
            t = 1 + {$random(seed)} % 8;
            h = 16 + {$random(seed)} % 16;
            tcs_pin_model_i.toggle(t, h);
            repeat (20) @(posedge clk_sys);
            chk(cap_cnt - base, exp_caps(st, t, e, p));
        end
        wr(TCS_OFF_ENPOL, 32'h0);
        wr(TCS_OFF_MODE, 32'h01);
        base = cap_cnt;
        tcs_pin_model_i.toggle(2, 20);
        chk(cap_cnt - base, 32'h0);
        wr(TCS_OFF_MODE, 32'hf1);
        if (tin === 1'b1) tcs_pin_model_i.toggle(1, 300);
        wr(TCS_OFF_ENPOL, 32'h1);
        base = cap_cnt;
        tcs_pin_model_i.toggle(2, 100);
        chk(cap_cnt - base, 32'h0);
        tcs_pin_model_i.toggle(2, 400);
        chk(cap_cnt - base, 32'h1);
        end_sim();
    end

    initial begin
        repeat (30000) @(posedge clk_sys);
        error_cnt++;
        $display("ERROR %0t: watchdog expired", $time);
        end_sim();
    end
endmodule
